// ### pss_defines.vh
// Purpose: shared constants of the power-state sequencer
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// =====================================================
// power states
`define PSS_ST_W       4
`define PSS_ST_OFF     4'h0
`define PSS_ST_STARTUP 4'h1
`define PSS_ST_READY   4'h2
`define PSS_ST_DSX     4'h3
`define PSS_ST_S54     4'h4
`define PSS_ST_S3      4'h5
`define PSS_ST_S0      4'h6
`define PSS_ST_STBY    4'h7
`define PSS_ST_ESD     4'h8

// =====================================================
// rail indices and rail groups
`define PSS_NRAIL      9
`define PSS_R_VR1      0
`define PSS_R_VR2      1
`define PSS_R_VR3      2
`define PSS_R_VR4      3
`define PSS_R_VR5      4
`define PSS_R_PCH      5
`define PSS_R_V085     6
`define PSS_R_SW18     7
`define PSS_R_IO       8
`define PSS_M_NONE     9'h000
`define PSS_M_DSW      9'h004
`define PSS_M_AON      9'h077
`define PSS_M_S3       9'h0ff
`define PSS_M_S0       9'h1ff
`define PSS_M_EXEMPT   9'h014
`define PSS_M_STBY_DVS 9'h017
`define PSS_M_MEM_DVS  9'h008

// =====================================================
// synchronised pin vector positions
`define PSS_PIN_W      21
`define PSS_P_VIN_OK   0
`define PSS_P_VIN_11V  1
`define PSS_P_VIN_9V9  2
`define PSS_P_BAT_5V4  3
`define PSS_P_LDO3_PG  4
`define PSS_P_LDO5_PG  5
`define PSS_P_CLK_PG   6
`define PSS_P_LOWPWR_N 7
`define PSS_P_MEMTERM  8
`define PSS_P_STBY_N   9
`define PSS_P_SLP4_N   10
`define PSS_P_SLP3_N   11
`define PSS_P_SUSP_N   12
`define PSS_P_SNS_3V3  13
`define PSS_P_SNS_1V8  14
`define PSS_P_SNS_1V0  15
`define PSS_P_PGG      16
`define PSS_P_PBTN     17
`define PSS_P_ADP      18
`define PSS_P_HWSD_N   19
`define PSS_P_OTEMP    20

// =====================================================
// shutdown cause flag positions
`define PSS_FA_VRFLT   0
`define PSS_FA_BTN     1
`define PSS_FA_HWSD    2
`define PSS_FA_SWSD    3
`define PSS_FB_THERM   0
`define PSS_FT_UV      2

// =====================================================
// timing
`define PSS_CLK_MHZ     250
`define PSS_BLANK_MS    10
`define PSS_DEGLITCH_US 30
`define PSS_BTN_TICK_US 1000

`endif

// ### pss_sequencer.v
// Purpose: power-state sequencer of a multi-rail power management device
// Assumes: pins asynchronous; control bits come from logic on sys_clk
// Notes:   rstn is the lockout reset; all outputs registered
// Behaviour
// - rail below power-good sets its fault flag; unmasked fault shuts down, except on exempt VR3 and VR5
// - discharge resistor connects while its rail is disabled and configured, and on every rail in shutdown
// - each rail takes its voltage setpoint from its control input
// - converter uses low-power setpoint while system low-power pin is low
// - power-good monitoring unaffected by low-power mode changes
// - memory-termination pin scales regulator 4; standby pin scales 1,2,3,5
// - smaller ramp above 11 V, larger again below 9.9 V
// - no operation under lockout; drop below lockout shuts down
// - clock-domain supply from LDO above 5.4 V, else from coin cell
// - off state enables no rail; clock and host interface stay inactive
// - startup ramps internal LDOs and reference, loads defaults after both good
// - clock-domain LDO enabled after 5 V LDO power-good
// - ready after default load and clock supply good; accepts enables
// - S5/S4 once always-on rails good; suspend-reset power-good goes high
// - sleep-state-4 high enters S3, enabling memory and switched 1.8 V
// - sleep-state-3 high, senses valid, group G and VR4 good: S0
// - standby falling edge with system power-good enters standby, scales/decays
// - deep sleep from startup on 3.3 V enable, from S5/S4 on sleep
// - emergency shutdown: power-ok low, all discharge on, all rails off
// - leave emergency shutdown on button fall, adapter rise, or lockout
// - shutdown causes recorded in cause flags; undervoltage in bit 2
// - faults ignored for 10 ms after a rail is enabled
// - fault declared only after more than 30 us outside window
`include "pss_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pss_sequencer #(
  parameter VW           = 8,
  parameter BW           = 22,
  parameter DW           = 13,
  parameter TW           = 18,
  parameter BLANK_CYC    = `PSS_BLANK_MS * 1000 * `PSS_CLK_MHZ,
  parameter DGL_CYC      = `PSS_DEGLITCH_US * `PSS_CLK_MHZ,
  parameter BTN_TICK_CYC = `PSS_BTN_TICK_US * `PSS_CLK_MHZ
) (
  // clock and lockout reset
  input  wire                         sys_clk,
  input  wire                         rstn,
  // supply comparators (async)
  input  wire                         vin_above_lockout,
  input  wire                         vin_above_11v,
  input  wire                         vin_above_9v9,
  input  wire                         battery_above_5v4,
  input  wire                         ldo_3v_pgood,
  input  wire                         ldo_5v_pgood,
  input  wire                         clock_supply_pgood,
  // platform pins (async)
  input  wire                         sys_lowpower_n,
  input  wire                         mem_term_ctrl,
  input  wire                         standby_n,
  input  wire                         sleep_state4_n,
  input  wire                         sleep_state3_n,
  input  wire                         suspend_sleep_n,
  input  wire                         sense_in_3v3,
  input  wire                         sense_in_1v8,
  input  wire                         sense_in_1v0,
  input  wire                         pgood_group_g,
  input  wire                         power_button_in,
  input  wire                         adapter_good,
  input  wire                         hw_shutdown_n,
  input  wire                         over_temp,
  input  wire [`PSS_NRAIL-1:0]        rail_pgood,
  // control bits (same clock)
  input  wire                         otp_load_done,
  input  wire [`PSS_NRAIL-1:0]        rail_enable_reg,
  input  wire [`PSS_NRAIL-1:0]        pgood_fault_mask,
  input  wire [`PSS_NRAIL-1:0]        discharge_config_a,
  input  wire [`PSS_NRAIL-1:0]        dvs_config,
  input  wire [`PSS_NRAIL-1:0]        decay_config,
  input  wire [`PSS_NRAIL*VW-1:0]     vset_normal,
  input  wire [`PSS_NRAIL*VW-1:0]     vset_lowpower,
  input  wire                         controller_sleep4_bit,
  input  wire                         controller_deep4_bit,
  input  wire                         sw_shutdown,
  input  wire [5:0]                   button_fault_time,
  input  wire [`PSS_NRAIL-1:0]        rail_fault_clear,
  input  wire                         cause_clear,
  // internal supply control
  output reg                          ldo_3v_internal_en_q,
  output reg                          ldo_5v_internal_en_q,
  output reg                          internal_reference_en_q,
  output reg                          clock_ldo_en_q,
  output reg                          clock_from_ldo_q,
  output reg                          otp_load_req_q,
  output reg                          host_if_active_q,
  output reg                          ramp_small_q,
  // rails
  output reg  [`PSS_NRAIL-1:0]        rail_en_q,
  output reg  [`PSS_NRAIL-1:0]        discharge_on_q,
  output reg  [`PSS_NRAIL*VW-1:0]     rail_vset_q,
  output reg  [`PSS_NRAIL-1:0]        rail_fault_q,
  // status to platform
  output reg  [`PSS_ST_W-1:0]         power_state_q,
  output reg                          suspend_reset_pgood_q,
  output reg                          system_power_good_q,
  output reg                          deep_sleep_power_ok_q,
  output reg  [7:0]                   shutdown_cause_flags_a_q,
  output reg  [7:0]                   shutdown_cause_flags_b_q,
  output reg  [7:0]                   top_level_int_flags_q
);

  // counts cut to their counter widths on purpose
  localparam integer  TICK_M1   = BTN_TICK_CYC - 1;
  localparam [BW-1:0] BLANK_LIM = BLANK_CYC[BW-1:0];
  localparam [DW-1:0] DGL_LIM   = DGL_CYC[DW-1:0];
  localparam [TW-1:0] TICK_LIM  = TICK_M1[TW-1:0];

  // =====================================================
  // input synchronisers
  reg  [`PSS_PIN_W-1:0] pin_m_q;
  reg  [`PSS_PIN_W-1:0] pin_s_q;
  reg  [`PSS_PIN_W-1:0] pin_p_q;
  reg  [`PSS_NRAIL-1:0] pg_m_q;
  reg  [`PSS_NRAIL-1:0] pg_s_q;
  wire [`PSS_PIN_W-1:0] pin_raw;

  assign pin_raw = {over_temp, hw_shutdown_n, adapter_good, power_button_in,
                    pgood_group_g, sense_in_1v0, sense_in_1v8, sense_in_3v3,
                    suspend_sleep_n, sleep_state3_n, sleep_state4_n, standby_n,
                    mem_term_ctrl, sys_lowpower_n, clock_supply_pgood,
                    ldo_5v_pgood, ldo_3v_pgood, battery_above_5v4,
                    vin_above_9v9, vin_above_11v, vin_above_lockout};

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_m_q <= {`PSS_PIN_W{1'b0}};
      pin_s_q <= {`PSS_PIN_W{1'b0}};
      pin_p_q <= {`PSS_PIN_W{1'b0}};
      pg_m_q  <= `PSS_M_NONE;
      pg_s_q  <= `PSS_M_NONE;
    end
    else
    begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
      pg_m_q  <= rail_pgood;
      pg_s_q  <= pg_m_q;
    end
  end

  wire vin_ok   = pin_s_q[`PSS_P_VIN_OK];
  wire ldo3_pg  = pin_s_q[`PSS_P_LDO3_PG];
  wire ldo5_pg  = pin_s_q[`PSS_P_LDO5_PG];
  wire stby_s   = pin_s_q[`PSS_P_STBY_N];
  wire btn_s    = pin_s_q[`PSS_P_PBTN];
  wire stby_fall = pin_p_q[`PSS_P_STBY_N] & ~stby_s;
  wire btn_fall  = pin_p_q[`PSS_P_PBTN] & ~btn_s;
  wire adp_rise  = ~pin_p_q[`PSS_P_ADP] & pin_s_q[`PSS_P_ADP];
  wire senses_ok = pin_s_q[`PSS_P_SNS_3V3] & pin_s_q[`PSS_P_SNS_1V8] &
                   pin_s_q[`PSS_P_SNS_1V0];

  // =====================================================
  // per-rail fault blanking, deglitch and setpoint
  wire [`PSS_NRAIL-1:0] flt_evt;
  wire [`PSS_NRAIL-1:0] lp_sel;

  // converter low-power setpoint follows its own pin
  // standby and memory-termination pins scale only the rails marked in their dvs bits
  assign lp_sel = (dvs_config & `PSS_M_STBY_DVS & {`PSS_NRAIL{~stby_s}}) |
                  (dvs_config & `PSS_M_MEM_DVS &
                   {`PSS_NRAIL{~pin_s_q[`PSS_P_MEMTERM]}}) |
                  ({{(`PSS_NRAIL-1){1'b0}}, ~pin_s_q[`PSS_P_LOWPWR_N]}
                   << `PSS_R_VR2);

  genvar i;
  generate
    for (i = 0; i < `PSS_NRAIL; i = i + 1)
    begin : g_rail
      reg [BW-1:0] blank_q;
      reg [DW-1:0] dgl_q;
      always @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          blank_q <= BLANK_LIM;
          dgl_q   <= {DW{1'b0}};
          rail_vset_q[i*VW +: VW] <= {VW{1'b0}};
        end
        else
        begin
          if (!rail_en_q[i])
            blank_q <= BLANK_LIM;
          else if (blank_q != {BW{1'b0}})
            blank_q <= blank_q - 1'b1;
          if (!rail_en_q[i] || blank_q != {BW{1'b0}} || pg_s_q[i])
            dgl_q <= {DW{1'b0}};
          else if (dgl_q != DGL_LIM)
            dgl_q <= dgl_q + 1'b1;
          // setpoint taken from the control input
          rail_vset_q[i*VW +: VW] <= lp_sel[i] ? vset_lowpower[i*VW +: VW]
                                               : vset_normal[i*VW +: VW];
        end
      end
      assign flt_evt[i] = (dgl_q == DGL_LIM) & rail_en_q[i] & ~pg_s_q[i];
    end
  endgenerate

  // =====================================================
  // power button hold timer
  reg  [TW-1:0] tick_q;
  reg  [5:0]    btn_cnt_q;
  wire          btn_long = ~btn_s & (btn_cnt_q > button_fault_time);

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_q    <= {TW{1'b0}};
      btn_cnt_q <= 6'h00;
    end
    else if (btn_s)
    begin
      tick_q    <= {TW{1'b0}};
      btn_cnt_q <= 6'h00;
    end
    else if (tick_q == TICK_LIM)
    begin
      tick_q <= {TW{1'b0}};
      if (btn_cnt_q != 6'h3f)
        btn_cnt_q <= btn_cnt_q + 1'b1;
    end
    else
      tick_q <= tick_q + 1'b1;
  end

  // =====================================================
  // shutdown causes
  wire act = (power_state_q != `PSS_ST_OFF) & (power_state_q != `PSS_ST_STARTUP) &
             (power_state_q != `PSS_ST_ESD);
  // unmasked faults on monitored rails trigger shutdown
  wire vr_trip  = |(flt_evt & ~pgood_fault_mask & ~`PSS_M_EXEMPT);
  wire hw_trip  = ~pin_s_q[`PSS_P_HWSD_N];
  wire ot_trip  = pin_s_q[`PSS_P_OTEMP];
  // any listed cause in an active state
  wire esd_go   = act & (vr_trip | hw_trip | sw_shutdown | ot_trip | btn_long);
  wire uv_trip  = ~vin_ok & (power_state_q != `PSS_ST_OFF);

  // =====================================================
  // state machine
  reg [`PSS_ST_W-1:0]  state_d;
  reg [`PSS_NRAIL-1:0] en_d;
  wire aon_good = ((rail_en_q & pg_s_q & `PSS_M_AON) == `PSS_M_AON);
  wire boot_ok  = otp_load_done & pin_s_q[`PSS_P_CLK_PG];

  always @*
  begin
    // hold unless an entry condition is met
    state_d = power_state_q;
    case (power_state_q)
      `PSS_ST_OFF:
        if (vin_ok)
          state_d = `PSS_ST_STARTUP;
      `PSS_ST_STARTUP:
        // defaults loaded and clock supply regulating
        // deep-sleep rail enable leads to deep sleep
        if (boot_ok)
          state_d = rail_enable_reg[`PSS_R_VR3] ? `PSS_ST_DSX : `PSS_ST_READY;
      `PSS_ST_READY:
        if (rail_enable_reg[`PSS_R_VR3])
          state_d = `PSS_ST_DSX;
      `PSS_ST_DSX:
        // all always-on rails enabled and good
        if (aon_good && suspend_sleep_n_ok(pin_s_q))
          state_d = `PSS_ST_S54;
      `PSS_ST_S54:
        // suspend sleep low or both controller bits
        if (!pin_s_q[`PSS_P_SUSP_N] || (controller_sleep4_bit && controller_deep4_bit))
          state_d = `PSS_ST_DSX;
        else if (pin_s_q[`PSS_P_SLP4_N])
          state_d = `PSS_ST_S3;
      `PSS_ST_S3:
        if (!pin_s_q[`PSS_P_SLP4_N])
          state_d = `PSS_ST_S54;
        // senses valid, group G and memory regulator good
        else if (pin_s_q[`PSS_P_SLP3_N] && senses_ok && pin_s_q[`PSS_P_PGG] &&
                 pg_s_q[`PSS_R_VR4])
          state_d = `PSS_ST_S0;
      `PSS_ST_S0:
        if (!pin_s_q[`PSS_P_SLP3_N])
          state_d = `PSS_ST_S3;
        // falling standby edge while system power-good
        else if (stby_fall && system_power_good_q)
          state_d = `PSS_ST_STBY;
      `PSS_ST_STBY:
        if (!pin_s_q[`PSS_P_SLP3_N])
          state_d = `PSS_ST_S3;
        else if (stby_s)
          state_d = `PSS_ST_S0;
      `PSS_ST_ESD:
        // a button fall or adapter rise releases it to ready; lockout forces off
        if (btn_fall || adp_rise)
          state_d = `PSS_ST_READY;
      default:
        state_d = `PSS_ST_OFF;
    endcase
    if (esd_go)
      state_d = `PSS_ST_ESD;
    if (!vin_ok)
      state_d = `PSS_ST_OFF;

    case (state_d)
      `PSS_ST_READY: en_d = rail_enable_reg & `PSS_M_AON;
      `PSS_ST_DSX:   en_d = (rail_enable_reg & `PSS_M_AON) | `PSS_M_DSW;
      `PSS_ST_S54:   en_d = `PSS_M_AON;
      // memory and switched 1.8 V rails on
      `PSS_ST_S3:    en_d = `PSS_M_S3;
      `PSS_ST_S0:    en_d = `PSS_M_S0;
      `PSS_ST_STBY:  en_d = `PSS_M_S0 & ~decay_config;
      // off, startup and shutdown enable nothing
      default:       en_d = `PSS_M_NONE;
    endcase
  end

  // suspend-sleep must be high to settle in S5/S4, else it falls straight back
  function suspend_sleep_n_ok;
    input [`PSS_PIN_W-1:0] p;
    begin
      suspend_sleep_n_ok = p[`PSS_P_SUSP_N];
    end
  endfunction

  // =====================================================
  // registered outputs
  wire in_sx = (state_d == `PSS_ST_S54) | (state_d == `PSS_ST_S3) |
               (state_d == `PSS_ST_S0) | (state_d == `PSS_ST_STBY);

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      power_state_q            <= `PSS_ST_OFF;
      rail_en_q                <= `PSS_M_NONE;
      discharge_on_q           <= `PSS_M_NONE;
      rail_fault_q             <= `PSS_M_NONE;
      ldo_3v_internal_en_q     <= 1'b0;
      ldo_5v_internal_en_q     <= 1'b0;
      internal_reference_en_q  <= 1'b0;
      clock_ldo_en_q           <= 1'b0;
      clock_from_ldo_q         <= 1'b0;
      otp_load_req_q           <= 1'b0;
      host_if_active_q         <= 1'b0;
      ramp_small_q             <= 1'b0;
      suspend_reset_pgood_q    <= 1'b0;
      system_power_good_q      <= 1'b0;
      deep_sleep_power_ok_q    <= 1'b0;
      shutdown_cause_flags_a_q <= 8'h00;
      shutdown_cause_flags_b_q <= 8'h00;
      top_level_int_flags_q    <= 8'h00;
    end
    else
    begin
      power_state_q  <= state_d;
      rail_en_q      <= en_d;
      // discharge on a disabled, configured rail, and on every rail in shutdown
      discharge_on_q <= (state_d == `PSS_ST_ESD) ? `PSS_M_S0
                                                 : (discharge_config_a & ~en_d);
      // sticky fault status, set wins over clear
      rail_fault_q   <= (rail_fault_q & ~rail_fault_clear) | flt_evt;
      // internal LDOs and reference ramp from startup on
      ldo_3v_internal_en_q    <= (state_d != `PSS_ST_OFF);
      ldo_5v_internal_en_q    <= (state_d != `PSS_ST_OFF);
      internal_reference_en_q <= (state_d != `PSS_ST_OFF);
      // defaults loaded once both LDOs are good
      otp_load_req_q <= (state_d == `PSS_ST_STARTUP) & ldo3_pg & ldo5_pg &
                        ~otp_load_done;
      // clock-domain LDO after 5 V LDO good
      clock_ldo_en_q <= (state_d != `PSS_ST_OFF) & ldo5_pg;
      // coin cell takes over below 5.4 V
      clock_from_ldo_q <= (state_d != `PSS_ST_OFF) & pin_s_q[`PSS_P_BAT_5V4] & ldo5_pg;
      // host interface and clock dead in off
      host_if_active_q <= (state_d != `PSS_ST_OFF) & (state_d != `PSS_ST_STARTUP);
      if (pin_s_q[`PSS_P_VIN_11V])
        ramp_small_q <= 1'b1;
      else if (!pin_s_q[`PSS_P_VIN_9V9])
        ramp_small_q <= 1'b0;
      suspend_reset_pgood_q <= in_sx;
      system_power_good_q   <= (state_d == `PSS_ST_S0) | (state_d == `PSS_ST_STBY);
      deep_sleep_power_ok_q <= in_sx | (state_d == `PSS_ST_DSX);
      // causes latched, set wins over clear
      shutdown_cause_flags_a_q <= (shutdown_cause_flags_a_q & {8{~cause_clear}}) |
                                  ({7'h00, act & vr_trip} << `PSS_FA_VRFLT) |
                                  ({7'h00, act & btn_long} << `PSS_FA_BTN) |
                                  ({7'h00, act & hw_trip} << `PSS_FA_HWSD) |
                                  ({7'h00, act & sw_shutdown} << `PSS_FA_SWSD);
      shutdown_cause_flags_b_q <= (shutdown_cause_flags_b_q & {8{~cause_clear}}) |
                                  ({7'h00, act & ot_trip} << `PSS_FB_THERM);
      top_level_int_flags_q    <= (top_level_int_flags_q & {8{~cause_clear}}) |
                                  ({7'h00, uv_trip} << `PSS_FT_UV);
    end
  end

endmodule // pss_sequencer

`default_nettype wire

// ### pss_properties.sv
// Purpose: port-level checks of the power-state sequencer
// Assumes: bound into pss_sequencer by the bench
// Notes:   state codes and rail masks come from pss_defines.vh
`include "pss_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pss_properties (
  // clock and lockout reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // watched ports
  input wire logic       vin_above_lockout,
  input wire logic [8:0] discharge_config_a,
  input wire logic [8:0] rail_en_q,
  input wire logic [8:0] discharge_on_q,
  input wire logic [3:0] power_state_q,
  input wire logic       system_power_good_q,
  input wire logic       suspend_reset_pgood_q,
  input wire logic       deep_sleep_power_ok_q,
  input wire logic       host_if_active_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========
  // state relations
  property p_off; power_state_q == `PSS_ST_OFF |-> rail_en_q == 9'h000 && !host_if_active_q;
  endproperty
  a_off: assert property (p_off) else $error("rail or host active in off");
  property p_dis; power_state_q != `PSS_ST_OFF && power_state_q != `PSS_ST_ESD
    |-> discharge_on_q == (discharge_config_a & ~rail_en_q); endproperty
  a_dis: assert property (p_dis) else $error("discharge not tied to rail off");
  property p_esd; power_state_q == `PSS_ST_ESD |-> rail_en_q == 9'h000
    && discharge_on_q == 9'h1ff && !deep_sleep_power_ok_q; endproperty
  a_esd: assert property (p_esd) else $error("shutdown outputs wrong");
  // pin seen two edges late, state on the third
  property p_uv; !vin_above_lockout [*4] |-> power_state_q == `PSS_ST_OFF; endproperty
  a_uv: assert property (p_uv) else $error("not off under lockout");
  property p_s54; power_state_q == `PSS_ST_S54 |-> suspend_reset_pgood_q
    && rail_en_q == `PSS_M_AON; endproperty
  a_s54: assert property (p_s54) else $error("s5 outputs wrong");
  property p_s3; power_state_q == `PSS_ST_S3 |-> rail_en_q == `PSS_M_S3
    && !system_power_good_q; endproperty
  a_s3: assert property (p_s3) else $error("s3 outputs wrong");
  property p_s0; power_state_q == `PSS_ST_S0 |-> rail_en_q == `PSS_M_S0
    && system_power_good_q; endproperty
  a_s0: assert property (p_s0) else $error("s0 outputs wrong");
  property p_stby; $rose(power_state_q == `PSS_ST_STBY) |-> $past(power_state_q) == `PSS_ST_S0
    && $past(system_power_good_q); endproperty
  a_stby: assert property (p_stby) else $error("standby entered from wrong state");
  property p_code; power_state_q <= `PSS_ST_ESD; endproperty
  a_code: assert property (p_code) else $error("illegal state code");
  c_s0: cover property (power_state_q == `PSS_ST_S0);
  c_stby: cover property (power_state_q == `PSS_ST_STBY);
  c_esd: cover property (power_state_q == `PSS_ST_ESD);
endmodule // pss_properties
`default_nettype wire

// ### pss_platform_model.sv
// Purpose: chipset side driving the sleep-state pins
// Assumes: level 0 deep sleep, 1 s5/s4, 2 s3, 3 s0
// Notes:   slow makes the pins lag a new level by several cycles
`timescale 1ns/1ps
`default_nettype none

module pss_platform_model (
  // clock and request
  input  wire logic       sys_clk,
  input  wire logic [1:0] level,
  input  wire logic       slow,
  // sleep pins
  output var  logic       suspend_sleep_n,
  output var  logic       sleep_state4_n,
  output var  logic       sleep_state3_n,
  output var  logic       sense_ok
);
  logic [1:0] lvl_q  = 2'h0;
  logic [3:0] wait_q = 4'h0;
  initial {suspend_sleep_n, sleep_state4_n, sleep_state3_n, sense_ok} = 4'h0;
  // ==========
  // pin sequencing
  always @(posedge sys_clk)
  begin
    lvl_q <= level;
    if (level != lvl_q)
      wait_q <= slow ? 4'h6 : 4'h0;
    else if (wait_q != 4'h0)
      wait_q <= wait_q - 4'h1;
    else
    begin
      suspend_sleep_n <= level != 2'h0;
      sleep_state4_n <= level[1];
      sleep_state3_n <= &level;
      sense_ok <= &level;
    end
  end
endmodule // pss_platform_model
`default_nettype wire

// ### pss_sequencer_tb.sv
// Purpose: self-checking bench of the power-state sequencer
// Assumes: shortened blanking, deglitch and tick counts
// Notes:   sleep pins come from the platform model
`include "pss_defines.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end

module pss_sequencer_tb;
  logic sys_clk = 1'b0, rstn = 1'b0, vin_above_lockout = 1'b1, vin_above_11v = 1'b0;
  logic vin_above_9v9 = 1'b0, battery_above_5v4 = 1'b1, ldo_3v_pgood = 1'b1, slow = 1'b0;
  logic ldo_5v_pgood = 1'b1, clock_supply_pgood = 1'b1, sys_lowpower_n = 1'b1;
  logic mem_term_ctrl = 1'b1, standby_n = 1'b1, pgood_group_g = 1'b1, cause_clear = 1'b0;
  logic power_button_in = 1'b1, adapter_good = 1'b0, hw_shutdown_n = 1'b1, over_temp = 1'b0;
  logic otp_load_done = 1'b1, controller_sleep4_bit = 1'b0, controller_deep4_bit = 1'b0;
  logic sw_shutdown = 1'b0;
  logic [1:0] level = 2'h1;
  logic [5:0] button_fault_time = 6'h3f;
  logic [8:0] rail_pgood = 9'h1ff, rail_enable_reg = `PSS_M_AON, pgood_fault_mask = 9'h000;
  logic [8:0] discharge_config_a, dvs_config, decay_config = 9'h000, rail_fault_clear = 9'h000;
  logic [71:0] vset_normal, vset_lowpower;
  wire ldo_3v_internal_en_q, ldo_5v_internal_en_q, internal_reference_en_q, clock_ldo_en_q;
  wire clock_from_ldo_q, otp_load_req_q, host_if_active_q, ramp_small_q, sense_ok;
  wire suspend_reset_pgood_q, system_power_good_q, deep_sleep_power_ok_q;
  wire suspend_sleep_n, sleep_state4_n, sleep_state3_n;
  wire [8:0] rail_en_q, discharge_on_q, rail_fault_q;
  wire [71:0] rail_vset_q;
  wire [3:0] power_state_q;
  wire [7:0] shutdown_cause_flags_a_q, shutdown_cause_flags_b_q, top_level_int_flags_q;
  wire sense_in_3v3 = sense_ok, sense_in_1v8 = sense_ok, sense_in_1v0 = sense_ok;
  int error_cnt = 0, n_tests = 0, k;

  pss_sequencer #(.BLANK_CYC(50), .DGL_CYC(8), .BTN_TICK_CYC(4)) u_pss_sequencer (.*);
  pss_platform_model u_pss_platform_model (.*);
  always #2 sys_clk = ~sys_clk;

  // ==========
  // helpers
  task automatic wrap_up;
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_st(input logic [3:0] s);
    for (int i = 0; i < 400 && power_state_q !== s; i++) cyc(1);
    `CHK("power_state", s, power_state_q)
    if (power_state_q !== s) wrap_up();
  endtask
  // low-power setpoints: converter on its own pin, others by pin and scaling bit
  function automatic logic [71:0] exp_vset(input logic lp, input logic mt, input logic sb);
    logic [8:0] low;
    low = {7'h0, !lp, 1'b0} | (dvs_config & (({9{!mt}} & `PSS_M_MEM_DVS)
          | ({9{!sb}} & `PSS_M_STBY_DVS)));
    for (int i = 0; i < 9; i++) exp_vset[i*8+:8] = low[i] ? vset_lowpower[i*8+:8]
                                                            : vset_normal[i*8+:8];
  endfunction

  // ==========
  // main sequence
  initial
  begin
    void'($urandom(32'he7bf5756));
    discharge_config_a = 9'($urandom);
    dvs_config = 9'($urandom) | 9'h009;
    vset_normal = 72'({$urandom, $urandom, $urandom});
    vset_lowpower = 72'({$urandom, $urandom, $urandom});
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    wait_st(`PSS_ST_S54);
    `CHK("clock_ldo_en", 1'b1, clock_ldo_en_q)
    `CHK("host_if", 1'b1, host_if_active_q)
    `CHK("int_sup", 4'he, {ldo_3v_internal_en_q, ldo_5v_internal_en_q,
         internal_reference_en_q, otp_load_req_q})
    @(posedge sys_clk);
    level <= 2'h2;
    wait_st(`PSS_ST_S3);
    @(posedge sys_clk);
    level <= 2'h3;
    wait_st(`PSS_ST_S0);
    for (k = 0; k < 5; k++)
    begin
      @(posedge sys_clk);
      {sys_lowpower_n, mem_term_ctrl, standby_n} <= {2'(k), k != 4};
      cyc(4);
      `CHK("rail_vset", exp_vset(k[1], k[0], k != 4), rail_vset_q)
      `CHK("lp_state", k == 4 ? `PSS_ST_STBY : `PSS_ST_S0, power_state_q)
    end
    @(posedge sys_clk);
    {sys_lowpower_n, mem_term_ctrl, standby_n} <= 3'b111;
    wait_st(`PSS_ST_S0);
    @(posedge sys_clk);
    {level, slow} <= 3'b001;
    wait_st(`PSS_ST_DSX);
    @(posedge sys_clk);
    level <= 2'h1;
    wait_st(`PSS_ST_S54);
    cyc(60);
    // short dip stays below the deglitch count
    @(posedge sys_clk);
    rail_pgood <= 9'h1fe;
    repeat (7) @(posedge sys_clk);
    rail_pgood <= 9'h1ff;
    cyc(12);
    `CHK("glitch_fault", 9'h000, rail_fault_q)
    @(posedge sys_clk);
    rail_pgood <= 9'h1fe;
    wait_st(`PSS_ST_ESD);
    `CHK("vr_fault", 2'b11, {rail_fault_q[0], shutdown_cause_flags_a_q[0]})
    // each pass: leave shutdown, then force the next cause
    for (k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      {rail_pgood, rail_fault_clear, cause_clear} <= {9'h1ff, 9'h1ff, 1'b1};
      {sw_shutdown, hw_shutdown_n, over_temp} <= 3'b010;
      if (k[0]) power_button_in <= 1'b0;
      else adapter_good <= 1'b1;
      wait_st(`PSS_ST_S54);
      @(posedge sys_clk);
      {rail_fault_clear, cause_clear, adapter_good, power_button_in} <= {9'h000, 3'b001};
      {sw_shutdown, hw_shutdown_n, over_temp} <= {k == 0, k != 1, k == 2};
      vin_above_lockout <= k != 3;
      wait_st(k == 3 ? `PSS_ST_OFF : `PSS_ST_ESD);
      `CHK("cause", 4'b0001 << k, {top_level_int_flags_q[2], shutdown_cause_flags_b_q[0],
           shutdown_cause_flags_a_q[2], shutdown_cause_flags_a_q[3]})
    end
    @(posedge sys_clk);
    vin_above_lockout <= 1'b1;
    wait_st(`PSS_ST_S54);
    for (k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      {vin_above_11v, vin_above_9v9, battery_above_5v4} <= {k == 1, k == 1 || k == 2, k[0]};
      cyc(4);
      `CHK("ramp_small", 1'(k == 1 || k == 2), ramp_small_q)
      `CHK("clock_from_ldo", k[0], clock_from_ldo_q)
    end
    wrap_up();
  end
endmodule // pss_sequencer_tb

bind pss_sequencer pss_properties u_pss_properties (.*);
`default_nettype wire
